// >>> adcc_pkg.sv
// Operation
// [R1] enable bit 15 turns converter on
// [R2] stop-in-idle bit 13 halts during idle
// [R3] resolution bit picks 12 or 10 bits
// [R4] 12-bit format field encodings
// [R5] 10-bit format field encodings
// [R6] fractional left-justifies, signed adds sign bit
// [R7] sample bit cleared, unwritable while off
// [R8] done cleared at next automatic sample
// [R9] sample and done: software and hardware access
// [R10] scan bits 13-0, 30-28 select inputs
// [R11] scan bits 27-14 and 31 read zero
// [R12] smaller packages drop upper scan bits
// [R13] control bits 31-16, 14, 12-11 read zero
// [R14] all implemented bits reset to zero
// [R15] done set when formatted result arrives
`default_nettype none
package adcc_pkg;
    // register byte offsets
    localparam logic [7:0]  CTRL_OFS        = 8'h00;
    localparam logic [7:0]  SCAN_OFS        = 8'h04;
    localparam logic [7:0]  IRQ_STAT_OFS    = 8'h08;
    localparam logic [7:0]  IRQ_MASK_OFS    = 8'h0c;
    localparam logic [7:0]  RESULT_OFS      = 8'h10;
    // control field positions
    localparam int          CTRL_ON_BIT     = 15;
    localparam int          CTRL_STOP_IN_IDLE_BIT   = 13;
    localparam int          CTRL_FMT_LSB    = 8;
    localparam int          CTRL_TRIG_LSB   = 4;
    localparam int          CTRL_RES12_BIT  = 3;
    localparam int          CTRL_AUTO_BIT   = 2;
    localparam int          CTRL_SAMPLE_ACTIVE_BIT   = 1;
    localparam int          CTRL_DONE_BIT   = 0;
    // interrupt status/mask bit positions
    localparam int          IRQ_DONE_BIT    = 0;
    localparam int          IRQ_SAMPLE_ACTIVE_BIT    = 1;
    localparam logic [1:0]  IRQ_IMPL_MASK   = 2'h3;
    // scan select implemented bits and package drops
    localparam logic [31:0] SCAN_IMPL_MASK  = 32'h7000_3fff;
    localparam logic [31:0] SCAN_DROP_20    = 32'h0000_3800;
    localparam logic [31:0] SCAN_DROP_28    = 32'h0000_3000;
    // reset values
    localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
    localparam logic [31:0] SCAN_RST        = 32'h0000_0000;
    localparam logic [31:0] RESULT_RST      = 32'h0000_0000;
    localparam logic [1:0]  IRQ_RST         = 2'h0;
    // output format codes
    localparam logic [2:0]  FMT_SFRAC32     = 3'h7;
    localparam logic [2:0]  FMT_FRAC32      = 3'h6;
    localparam logic [2:0]  FMT_SINT32      = 3'h5;
    localparam logic [2:0]  FMT_INT32       = 3'h4;
    localparam logic [2:0]  FMT_SFRAC16     = 3'h3;
    localparam logic [2:0]  FMT_FRAC16      = 3'h2;
    localparam logic [2:0]  FMT_INT16       = 3'h0;

    typedef enum logic
    {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } adcc_bus_st_t;
endpackage : adcc_pkg
`default_nettype wire

// >>> adcc_fmt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface adcc_fmt_if;
    logic [11:0] raw;
    logic        res12;
    logic [2:0]  fmt;
    logic [31:0] word;

    modport ctrl (output raw, output res12, output fmt, input word);
    modport enc  (input raw, input res12, input fmt, output word);
endinterface : adcc_fmt_if
`default_nettype wire

// >>> adcc_format.sv
`timescale 1ns/1ns
`default_nettype none
module adcc_format
    import adcc_pkg::*;
(
    adcc_fmt_if.enc f
);
    logic [11:0] sgn12;
    logic [9:0]  val10;
    logic [9:0]  sgn10;

    // signed forms take offset binary to two's complement by flipping the msb
    assign sgn12 = {~f.raw[11], f.raw[10:0]};
    assign val10 = f.raw[9:0];
    assign sgn10 = {~val10[9], val10[8:0]};

    always_comb
    begin
        if (f.res12) // [R3]
        begin
            case (f.fmt) // [R4] [R6]
                FMT_SFRAC32: f.word = {sgn12, 20'h00000};
                FMT_FRAC32:  f.word = {f.raw, 20'h00000};
                FMT_SINT32:  f.word = {{20{sgn12[11]}}, sgn12};
                FMT_SFRAC16: f.word = {16'h0000, sgn12, 4'h0};
                FMT_FRAC16:  f.word = {16'h0000, f.raw, 4'h0};
                // code 100 is not defined at 12 bits, falls back to integer
                default:     f.word = {20'h00000, f.raw};
            endcase
        end
        else
        begin
            case (f.fmt) // [R5] [R6]
                FMT_SFRAC32: f.word = {sgn10, 22'h000000};
                FMT_FRAC32:  f.word = {val10, 22'h000000};
                FMT_SINT32:  f.word = {{22{sgn10[9]}}, sgn10};
                FMT_INT32:   f.word = {22'h000000, val10};
                FMT_SFRAC16: f.word = {16'h0000, sgn10, 6'h00};
                FMT_FRAC16:  f.word = {16'h0000, val10, 6'h00};
                default:     f.word = {22'h000000, val10};
            endcase
        end
    end
endmodule : adcc_format
`default_nettype wire

// >>> adcc_top.sv
`timescale 1ns/1ns
`default_nettype none
module adcc_top
    import adcc_pkg::*;
#(
    parameter int PKG_PINS = 36
)
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        idle_i,
    input  wire logic        sample_start_i,
    input  wire logic        sample_end_i,
    input  wire logic        conv_done_i,
    input  wire logic [11:0] raw_sample_i,
    output logic             module_run_o,
    output logic             sample_active_o,
    output logic             resolution_12b_sel_o,
    output logic      [31:0] scan_input_sel_o,
    output logic      [31:0] result_o,
    output logic             irq_o
);
    localparam logic [31:0] SCAN_MASK =
        (PKG_PINS == 20) ? (SCAN_IMPL_MASK & ~SCAN_DROP_20) :
        (PKG_PINS == 28) ? (SCAN_IMPL_MASK & ~SCAN_DROP_28) : SCAN_IMPL_MASK;

    adcc_bus_st_t bus_st_q;
    logic         req;
    logic         wr_acc;
    logic [31:0]  be_mask;
    logic [31:0]  rdata_d;
    logic [31:0]  rdata_q;
    logic         on_q;
    logic         stop_in_idle_q;
    logic [2:0]   fmt_q;
    logic [3:0]   trig_q;
    logic         res12_q;
    logic         auto_q;
    logic         sample_active_q;
    logic         done_q;
    logic [31:0]  ctrl_rd;
    logic [31:0]  ctrl_wr;
    logic [31:0]  scan_q;
    logic [31:0]  result_q;
    logic [1:0]   irq_stat_q;
    logic [1:0]   irq_mask_q;
    logic         wr_ctrl;
    logic         wr_scan;
    logic         wr_stat;
    logic         wr_mask;
    logic         done_evt;
    logic         sample_active_evt;

    adcc_fmt_if fmt_bus ();

    adcc_format u_format
    (
        .f (fmt_bus.enc)
    );

    assign fmt_bus.raw   = raw_sample_i;
    assign fmt_bus.res12 = res12_q; // [R3]
    assign fmt_bus.fmt   = fmt_q;

    // one wait state per access keeps read data registered
    assign req               = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req && (bus_st_q == BUS_IDLE);
    assign wr_acc            = avs_write_i && (bus_st_q == BUS_ACK);
    assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            bus_st_q <= BUS_IDLE;
        else
        begin
            case (bus_st_q)
                BUS_IDLE: if (req) bus_st_q <= BUS_ACK;
                default:  bus_st_q <= BUS_IDLE;
            endcase
        end
    end

    assign wr_ctrl = wr_acc && (avs_address_i == CTRL_OFS);
    assign wr_scan = wr_acc && (avs_address_i == SCAN_OFS);
    assign wr_stat = wr_acc && (avs_address_i == IRQ_STAT_OFS);
    assign wr_mask = wr_acc && (avs_address_i == IRQ_MASK_OFS);

    // reserved control bits are never stored, so they read zero
    assign ctrl_rd = {16'h0000, on_q, 1'b0, stop_in_idle_q, 2'b00, fmt_q,
                      trig_q, res12_q, auto_q, sample_active_q, done_q}; // [R13]
    assign ctrl_wr = (ctrl_rd & ~be_mask) | (avs_writedata_i & be_mask);

    // the idle stop only gates the core, the registers stay reachable
    assign module_run_o = on_q && !(stop_in_idle_q && idle_i); // [R1] [R2]
    assign done_evt     = conv_done_i && module_run_o;
    assign sample_active_evt     = sample_start_i && module_run_o;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            on_q    <= CTRL_RST[CTRL_ON_BIT]; // [R14]
            stop_in_idle_q  <= CTRL_RST[CTRL_STOP_IN_IDLE_BIT];
            fmt_q   <= CTRL_RST[CTRL_FMT_LSB +: 3];
            trig_q  <= CTRL_RST[CTRL_TRIG_LSB +: 4];
            res12_q <= CTRL_RST[CTRL_RES12_BIT];
            auto_q  <= CTRL_RST[CTRL_AUTO_BIT];
        end
        else if (wr_ctrl)
        begin
            on_q    <= ctrl_wr[CTRL_ON_BIT]; // [R1]
            stop_in_idle_q  <= ctrl_wr[CTRL_STOP_IN_IDLE_BIT]; // [R2]
            fmt_q   <= ctrl_wr[CTRL_FMT_LSB +: 3];
            trig_q  <= ctrl_wr[CTRL_TRIG_LSB +: 4];
            res12_q <= ctrl_wr[CTRL_RES12_BIT]; // [R3]
            auto_q  <= ctrl_wr[CTRL_AUTO_BIT];
        end
    end

    // sample bit: hardware set beats software and hardware clear
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            sample_active_q <= CTRL_RST[CTRL_SAMPLE_ACTIVE_BIT]; // [R14]
        else if (!on_q)
            sample_active_q <= 1'b0; // [R7]
        else if (sample_active_evt)
            sample_active_q <= 1'b1; // [R9]
        else if (sample_end_i)
            sample_active_q <= 1'b0; // [R9]
        else if (wr_ctrl && ctrl_wr[CTRL_ON_BIT])
            sample_active_q <= ctrl_wr[CTRL_SAMPLE_ACTIVE_BIT]; // [R7] [R9]
    end

    // done flag: a finishing conversion wins over any clear
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            done_q <= CTRL_RST[CTRL_DONE_BIT]; // [R14]
        else if (done_evt)
            done_q <= 1'b1; // [R15] [R9]
        else if (auto_q && sample_active_evt)
            done_q <= 1'b0; // [R8]
        else if (wr_ctrl)
            done_q <= ctrl_wr[CTRL_DONE_BIT]; // [R9]
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            scan_q <= SCAN_RST; // [R14]
        else if (wr_scan)
            scan_q <= ((scan_q & ~be_mask) | (avs_writedata_i & be_mask))
                      & SCAN_MASK; // [R10] [R11] [R12]
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            result_q <= RESULT_RST;
        else if (done_evt)
            result_q <= fmt_bus.word; // [R15]
    end

    // sticky events, write one to clear, new event wins
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            irq_stat_q <= IRQ_RST;
        else
        begin
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? avs_writedata_i[1:0] & be_mask[1:0] : 2'h0))
                          | {sample_active_evt, done_evt};
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            irq_mask_q <= IRQ_RST;
        else if (wr_mask && avs_byteenable_i[0])
            irq_mask_q <= avs_writedata_i[1:0] & IRQ_IMPL_MASK;
    end

    // read data latched in the wait cycle, stands while waitrequest is low
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (avs_address_i == CTRL_OFS)
            rdata_d = ctrl_rd;
        else if (avs_address_i == SCAN_OFS)
            rdata_d = scan_q; // [R11]
        else if (avs_address_i == IRQ_STAT_OFS)
            rdata_d = {30'h0, irq_stat_q};
        else if (avs_address_i == IRQ_MASK_OFS)
            rdata_d = {30'h0, irq_mask_q};
        else if (avs_address_i == RESULT_OFS)
            rdata_d = result_q;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            rdata_q <= 32'h0000_0000;
        else if (avs_read_i && (bus_st_q == BUS_IDLE))
            rdata_q <= rdata_d;
    end

    assign avs_readdata_o       = rdata_q;
    assign sample_active_o      = sample_active_q;
    assign resolution_12b_sel_o = res12_q;
    assign scan_input_sel_o     = scan_q;
    assign result_o             = result_q;
    assign irq_o                = |(irq_stat_q & irq_mask_q);

    a_run_needs_on: assert property ( // [R1]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        module_run_o |-> on_q)
        else $error("core runs while module is off");

    a_idle_stop: assert property ( // [R2]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (stop_in_idle_q && idle_i) |-> !module_run_o)
        else $error("core runs in idle with stop-in-idle set");

    a_sample_active_off: assert property ( // [R7]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !on_q |=> !sample_active_q)
        else $error("sample bit set while module off");

    a_done_set: assert property ( // [R15]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        done_evt |=> done_q && (result_q == $past(fmt_bus.word)))
        else $error("done or result not updated on conversion");

    a_done_auto_clr: assert property ( // [R8]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (auto_q && sample_active_evt && !done_evt) |=> !done_q)
        else $error("done not cleared at automatic sample start");

    a_fmt_int12: assert property ( // [R4]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (res12_q && fmt_q == FMT_INT16) |-> fmt_bus.word == {20'h00000, raw_sample_i})
        else $error("12-bit integer format wrong");

    a_fmt_frac10: assert property ( // [R5]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!res12_q && fmt_q == FMT_FRAC16)
            |-> fmt_bus.word == {16'h0000, raw_sample_i[9:0], 6'h00})
        else $error("10-bit fractional format wrong");

    a_sign_ext: assert property ( // [R6]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!res12_q && fmt_q == FMT_SINT32)
            |-> fmt_bus.word[31:9] == {23{~raw_sample_i[9]}})
        else $error("signed integer not sign extended");

    a_scan_holes: assert property ( // [R11] [R12]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (scan_q & ~SCAN_MASK) == 32'h0000_0000)
        else $error("unimplemented scan bit set");

    a_ctrl_rsvd: assert property ( // [R13]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (avs_read_i && !avs_waitrequest_o && avs_address_i == CTRL_OFS)
            |-> (avs_readdata_o & 32'hffff_5800) == 32'h0000_0000)
        else $error("reserved control bit reads nonzero");

    a_bus_one_wait: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("waitrequest held over one cycle");

    a_reset_zero: assert property ( // [R14]
        @(posedge ref_clk_i)
        !rst_n_i |=> (ctrl_rd == 32'h0000_0000) && (scan_q == 32'h0000_0000))
        else $error("register not zero after reset");

    a_on_write: assert property ( // [R1]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_ctrl |=> on_q == $past(ctrl_wr[CTRL_ON_BIT]))
        else $error("enable bit not taken from write");

    a_res_write: assert property ( // [R3]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_ctrl |=> res12_q == $past(ctrl_wr[CTRL_RES12_BIT]))
        else $error("resolution bit not taken from write");

    a_sample_active_set: assert property ( // [R9]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        sample_active_evt |=> sample_active_q)
        else $error("sample bit not set at sample start");

    a_sample_active_clr: assert property ( // [R9]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (sample_end_i && !sample_active_evt) |=> !sample_active_q)
        else $error("sample bit not cleared at sample end");

    a_done_sticky: assert property ( // [R9]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (done_q && !wr_ctrl && !(auto_q && sample_active_evt)) |=> done_q)
        else $error("done flag lost without a clear");

    a_scan_write: assert property ( // [R10]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr_scan && avs_byteenable_i == 4'hf)
            |=> scan_q == ($past(avs_writedata_i) & SCAN_MASK))
        else $error("scan select not taken from write");

    a_fmt_sfrac12: assert property ( // [R4] [R6]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (res12_q && fmt_q == FMT_SFRAC32)
            |-> fmt_bus.word == {~raw_sample_i[11], raw_sample_i[10:0], 20'h00000})
        else $error("12-bit signed fractional format wrong");

    a_fmt_sint12: assert property ( // [R4] [R6]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (res12_q && fmt_q == FMT_SINT32)
            |-> fmt_bus.word == {{21{~raw_sample_i[11]}}, raw_sample_i[10:0]})
        else $error("12-bit signed integer format wrong");

    a_fmt_frac12: assert property ( // [R4]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (res12_q && fmt_q == FMT_FRAC16)
            |-> fmt_bus.word == {16'h0000, raw_sample_i, 4'h0})
        else $error("12-bit fractional format wrong");

    a_fmt_int32: assert property ( // [R5]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!res12_q && fmt_q == FMT_INT32)
            |-> fmt_bus.word == {22'h000000, raw_sample_i[9:0]})
        else $error("10-bit wide integer format wrong");

    a_fmt_sfrac10: assert property ( // [R5] [R6]
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!res12_q && fmt_q == FMT_SFRAC16)
            |-> fmt_bus.word == {16'h0000, ~raw_sample_i[9], raw_sample_i[8:0], 6'h00})
        else $error("10-bit signed fractional format wrong");
endmodule : adcc_top
`default_nettype wire

// >>> adcc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module adcc_core_model
(
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [3:0]  dly_i,
    input  wire logic [11:0] raw_i,
    output logic             sample_start_o,
    output logic             sample_end_o,
    output logic             conv_done_o,
    output logic      [11:0] raw_o
);
    logic [4:0]  cnt_q = 5'h0;
    logic [11:0] val_q = 12'h0;
    initial sample_start_o = 1'b0;
    initial sample_end_o = 1'b0;
    initial conv_done_o = 1'b0;
    initial raw_o = 12'h0;
    // a sample opens, closes dly_i+1 cycles later, then the result is offered
    always @(posedge clk_i)
    begin
        sample_start_o <= 1'b0;
        sample_end_o <= 1'b0;
        conv_done_o <= 1'b0;
        // the data lines only hold a sample in the done cycle, else they wander
        raw_o <= ~raw_o;
        if (go_i && cnt_q == 5'h0)
        begin
            sample_start_o <= 1'b1;
            cnt_q <= {1'b0, dly_i} + 5'h2;
            val_q <= raw_i;
        end
        else if (cnt_q != 5'h0)
        begin
            cnt_q <= cnt_q - 5'h1;
            sample_end_o <= (cnt_q == 5'h2);
            if (cnt_q == 5'h1)
            begin
                conv_done_o <= 1'b1;
                raw_o <= val_q;
            end
        end
    end
endmodule : adcc_core_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import adcc_pkg::*;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, idle_i = 1'b0;
    logic [7:0] avs_address_i = 8'h0;
    logic avs_read_i = 1'b0, avs_write_i = 1'b0, go = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, scan_input_sel_o, result_o, q;
    logic avs_waitrequest_o, module_run_o, sample_active_o, irq_o, res12;
    logic ss, se, cd;
    logic [11:0] raw, raw_in = 12'h0;
    logic [3:0] dly = 4'h1;
    int bad_count = 0, n_compared = 0, cyc = 0;
    adcc_top adcc_top_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .idle_i(idle_i), .sample_start_i(ss), .sample_end_i(se), .conv_done_i(cd),
        .raw_sample_i(raw), .module_run_o(module_run_o), .sample_active_o(sample_active_o),
        .resolution_12b_sel_o(res12), .scan_input_sel_o(scan_input_sel_o),
        .result_o(result_o), .irq_o(irq_o));
    adcc_core_model adcc_core_model_inst (.clk_i(ref_clk_i), .go_i(go), .dly_i(dly),
        .raw_i(raw_in), .sample_start_o(ss), .sample_end_o(se), .conv_done_o(cd),
        .raw_o(raw));
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            stop_test();
        end
    end
    task stop_test;
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= ~w;
        // waitrequest and readdata are read at the edge, before it updates them
        do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : bus
    task rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rdc
    // fixed wait: the model answers a fixed count of edges after go
    task convert(input logic [11:0] r, input logic [3:0] d);
        @(posedge ref_clk_i);
        go <= 1'b1;
        raw_in <= r;
        dly <= d;
        @(posedge ref_clk_i);
        go <= 1'b0;
        repeat (d + 4) @(posedge ref_clk_i);
        #1;
    endtask : convert
    function automatic logic [31:0] fmt_exp(input logic r12, input logic [2:0] f,
                                            input logic [11:0] x);
        logic [11:0] l;
        logic [31:0] i, s;
        l = r12 ? x : {x[9:0], 2'h0};
        i = r12 ? {20'h0, x} : {22'h0, x[9:0]};
        s = r12 ? {{21{~x[11]}}, x[10:0]} : {{23{~x[9]}}, x[8:0]};
        case (f)
            3'h7: return {~l[11], l[10:0], 20'h0};
            3'h6: return {l, 20'h0};
            3'h5: return s;
            3'h3: return {16'h0, ~l[11], l[10:0], 4'h0};
            3'h2: return {16'h0, l, 4'h0};
            default: return i;
        endcase
    endfunction : fmt_exp
    task s_reset;
        rdc(CTRL_OFS, 32'h0);
        rdc(SCAN_OFS, 32'h0);
        rdc(RESULT_OFS, 32'h0);
        rdc(IRQ_STAT_OFS, 32'h0);
        rdc(IRQ_MASK_OFS, 32'h0);
        bus(1'b1, 8'h14, 32'hffff_ffff);
        rdc(8'h14, 32'h0);
        rdc(CTRL_OFS, 32'h0);
    endtask : s_reset
    task s_ctrl;
        // sample bit is refused while the module is still off
        bus(1'b1, CTRL_OFS, 32'hffff_ffff);
        rdc(CTRL_OFS, 32'h0000_a7fd);
        bus(1'b1, CTRL_OFS, 32'hffff_ffff);
        rdc(CTRL_OFS, 32'h0000_a7ff);
        chk(32'(sample_active_o), 32'h1);
        bus(1'b1, CTRL_OFS, 32'h0);
        bus(1'b1, CTRL_OFS, 32'h2);
        rdc(CTRL_OFS, 32'h0);
        chk(32'(sample_active_o), 32'h0);
        bus(1'b1, SCAN_OFS, 32'hffff_ffff);
        rdc(SCAN_OFS, 32'h7000_3fff);
        chk(scan_input_sel_o, 32'h7000_3fff);
    endtask : s_ctrl
    task s_formats;
        logic [11:0] rv[2];
        rv = '{12'h9a5, 12'h35a};
        for (int r = 0; r < 2; r++)
            for (int f = 0; f < 8; f++)
                for (int k = 0; k < 2; k++)
                    if (f != 1 && !(r == 1 && f == 4))
                    begin
                        bus(1'b1, CTRL_OFS, 32'h8000 | (f << 8) | (r << 3));
                        #1;
                        chk(32'(res12), 32'(r));
                        convert(rv[k], 4'h1);
                        chk(result_o, fmt_exp(r[0], f[2:0], rv[k]));
                        rdc(RESULT_OFS, fmt_exp(r[0], f[2:0], rv[k]));
                        rdc(CTRL_OFS, 32'h8001 | (f << 8) | (r << 3));
                    end
    endtask : s_formats
    task s_irq;
        bus(1'b1, IRQ_STAT_OFS, 32'h3);
        bus(1'b1, IRQ_MASK_OFS, 32'h1);
        #1;
        chk(32'(irq_o), 32'h0);
        convert(12'h123, 4'h2);
        chk(32'(irq_o), 32'h1);
        rdc(IRQ_STAT_OFS, 32'h3);
        bus(1'b1, IRQ_STAT_OFS, 32'h1);
        rdc(IRQ_STAT_OFS, 32'h2);
        chk(32'(irq_o), 32'h0);
        bus(1'b1, IRQ_MASK_OFS, 32'h2);
        #1;
        chk(32'(irq_o), 32'h1);
        bus(1'b1, IRQ_STAT_OFS, 32'h2);
        #1;
        chk(32'(irq_o), 32'h0);
    endtask : s_irq
    task s_idle;
        bus(1'b1, CTRL_OFS, 32'h8000);
        idle_i <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        chk(32'(module_run_o), 32'h1);
        bus(1'b1, CTRL_OFS, 32'ha000);
        #1;
        chk(32'(module_run_o), 32'h0);
        convert(12'h777, 4'h1);
        // result still holds the last conversion, 12-bit signed fractional
        chk(result_o, fmt_exp(1'b1, FMT_SFRAC32, 12'h123));
        @(posedge ref_clk_i);
        idle_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        chk(32'(module_run_o), 32'h1);
        bus(1'b1, CTRL_OFS, 32'h2000);
        #1;
        chk(32'(module_run_o), 32'h0);
    endtask : s_idle
    task s_auto;
        bus(1'b1, CTRL_OFS, 32'h8004);
        convert(12'h456, 4'h1);
        rdc(CTRL_OFS, 32'h8005);
        @(posedge ref_clk_i);
        go <= 1'b1;
        dly <= 4'ha;
        @(posedge ref_clk_i);
        go <= 1'b0;
        rdc(CTRL_OFS, 32'h8006);
        repeat (12) @(posedge ref_clk_i);
        rdc(CTRL_OFS, 32'h8005);
    endtask : s_auto
    initial
    begin
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        s_reset();
        s_ctrl();
        s_formats();
        s_irq();
        s_idle();
        s_auto();
        stop_test();
    end
endmodule : tb
`default_nettype wire
